// ### src/pmca_pkg.sv
// Purpose: Shared constants and types of the channel access block
// Assumes: 125 MHz clock, 32-bit AHB-Lite register bus
// Notes:   Offsets are byte addresses of aligned words
package pmca_pkg;
  // Register byte offsets
  localparam logic [7:0] CFG_OFS    = 8'h00;
  localparam logic [7:0] TXCTL_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] TXFCS_OFS  = 8'h0c;
  // Configuration reset values
  localparam logic [3:0] MIN_BE_RST = 4'h3;
  localparam logic [3:0] MAX_BE_RST = 4'h5;
  localparam logic [3:0] NB_LIM_RST = 4'h4;
  localparam logic [3:0] RTY_RST    = 4'h3;
  localparam logic [7:0] SPB_RST    = 8'h01;
  localparam logic [7:0] HPW_RST    = 8'h04;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  // Status bit positions
  localparam int ST_DONE = 4;
  localparam int ST_CAF  = 5;
  localparam int ST_NACK = 6;
  // Response wait time and derived cycle count
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESP_WAIT_NS  = 4000;
  localparam int RESP_WAIT_CYC = RESP_WAIT_NS / CLK_PERIOD_NS;
  // Response kinds reported by the receive path
  localparam logic [1:0] RESP_ACK  = 2'h1;
  localparam logic [1:0] RESP_NACK = 2'h2;
  // AHB transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // Configuration register layout
  typedef struct packed {
    logic [7:0] hp_window_slots;  // high_priority_window_slots
    logic [7:0] sym_per_period;   // symbols_per_backoff_period
    logic [3:0] frame_retry_limit;
    logic [3:0] attempt_limit;    // backoff_attempt_limit
    logic [3:0] max_be;           // max_backoff_exponent
    logic [3:0] min_be;           // min_backoff_exponent
  } pmca_cfg_s;
  // Transmit request layout (bits 31:26 and 15:13 unused)
  typedef struct packed {
    logic [5:0] unused;
    logic [9:0] seg_length;
    logic [2:0] spare;            // Gap above the segment count
    logic [5:0] seg_count;
    logic       last_seg;
    logic       tone_map_req;
    logic       burst;
    logic       group_addr;
    logic       ack_req;
    logic       high_prio;
    logic       start;
  } pmca_txctl_s;
  // Three-byte segment control header, byte 0 in the top bits
  typedef struct packed {
    logic [3:0] unused_upper_bits;
    logic       tone_map_request;
    logic       contention_control;
    logic       access_priority_flag;
    logic       last_segment_flag;
    logic [5:0] segment_count;
    logic [9:0] segment_length;
  } pmca_seghdr_s;
  // Access sequencer states, Gray coded along the main path
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_BACKOFF = 3'b001,
    ST_SENSE   = 3'b011,
    ST_TX      = 3'b010,
    ST_ACKWAIT = 3'b110
  } pmca_state_e;
endpackage

// ### src/pmca_top.sv
// Function
// - Back off before every data/command transmission except bursts
// - Delays counted in whole backoff periods
// - Clear attempt counter per new attempt
// - Load exponent from minimum each attempt
// - Random 0..2^exp-1 periods, then sense
// - Busy: bump counter and exponent, saturate
// - High priority may set max equal min
// - Retry until limit exceeded, then failure
// - Idle channel: transmit at once
// - High priority window precedes normal window
// - Window sizes from slots and exponent
// - First slot reserved for bursting
// - Missing ack: retransmit, bounded retries
// - No ack request for group traffic
// - Ack only own packets with good FCS
// - Ack carries received packet FCS
// - Accept ack only with matching FCS
// - Unhandled frame gets no ack
// - Retries keep sequence; duplicates discarded (code only flags them on RX_DUP_O and still acks them)
// - Segments acknowledged and retried independently
// - Header byte 0 field layout
// - Header count and length layout
// - Header flag encodings
// - Missing or foreign response is collision
//
// Purpose: Unslotted CSMA-CA, priority windows, ARQ and ack generation
// Assumes: PHY and receive path share CLOCK_I; one segment per request
// Notes:   Software issues one request per segment
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
module pmca_top (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  output logic [31:0]      HRDATA_O,
  input  wire logic        SYM_TICK_I,
  output logic             CS_REQ_O,
  input  wire logic        CS_VALID_I,
  input  wire logic        CS_BUSY_I,
  output logic             TX_START_O,
  output logic             TX_ACK_REQ_O,
  output logic [23:0]      SEG_HDR_O,
  input  wire logic        TX_DONE_I,
  input  wire logic        RESP_VALID_I,
  input  wire logic [1:0]  RESP_KIND_I,
  input  wire logic [15:0] RESP_FCS_I,
  input  wire logic        RX_VALID_I,
  input  wire logic        RX_FCS_OK_I,
  input  wire logic        RX_FOR_ME_I,
  input  wire logic        RX_CAN_HANDLE_I,
  input  wire logic [15:0] RX_FCS_I,
  input  wire logic [7:0]  RX_SEQ_I,
  input  wire logic [5:0]  RX_SEG_CNT_I,
  output logic             ACK_REQ_O,
  output logic [15:0]      ACK_FCS_O,
  output logic             RX_DUP_O
);
  pmca_pkg::pmca_cfg_s   cfg_r;      // Configuration register
  pmca_pkg::pmca_txctl_s txctl_r;    // Current transmit request
  pmca_pkg::pmca_state_e state_r;    // Access sequencer state
  logic [15:0]           txfcs_r;    // FCS of frame being sent
  logic [2:0]            sticky_r;   // Done, channel fail, no-ack fail
  logic [3:0]            nb_r;       // backoff_attempt_count
  logic [3:0]            be_r;       // backoff_exponent
  logic [3:0]            rtry_r;     // Retransmissions so far
  logic [15:0]           slots_r;    // Backoff periods still to wait
  logic [7:0]            sym_r;      // Symbols inside current period
  logic [15:0]           lfsr_r;     // Pseudo-random source
  logic [15:0]           resp_cnt_r; // Response wait timer
  logic [7:0]            last_seq_r; // Last accepted sequence
  logic [5:0]            last_sc_r;  // Last accepted segment count
  logic                  last_ok_r;  // Last pair is valid
  // Bus data-phase capture
  logic                  wr_pend_r;
  logic [7:0]            wr_addr_r;
  logic [31:0]           rdata_r;
  // Decoded events
  logic                  acc;        // Address phase accepted
  logic                  start_wr;   // Software start request
  logic                  st_clr;     // Status write-one-to-clear
  logic                  period_end; // One backoff period elapsed
  logic                  want_ack;   // Response expected
  logic                  ack_hit;    // Matching acknowledgement
  logic                  collide;    // Collision inferred
  logic                  nb_over;    // Attempt limit exceeded
  logic                  rtry_over;  // Retry limit exceeded
  logic [15:0]           rand_mask;  // 2^exp - 1
  logic [15:0]           delay;      // Periods for a new backoff
  logic [3:0]            be_inc;     // Saturated exponent step
  logic [3:0]            be_nxt;     // Exponent after this edge
  pmca_pkg::pmca_txctl_s txctl_nxt;  // Request after this edge
  logic [31:0]           rd_mux;     // Read data selection

  // Zero wait state slave, always OKAY
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign HRDATA_O    = rdata_r;
  assign acc = HSEL_I & HREADY_I & (HTRANS_I == pmca_pkg::HTRANS_NONSEQ);
  assign start_wr = wr_pend_r & (wr_addr_r == pmca_pkg::TXCTL_OFS)
                    & HWDATA_I[0] & (state_r == pmca_pkg::ST_IDLE);
  assign st_clr = wr_pend_r & (wr_addr_r == pmca_pkg::STATUS_OFS);

  // Capture write address phase
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= acc & HWRITE_I;
      wr_addr_r <= HADDR_I[7:0];
    end
  end

  // Read data mux, unmapped words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (HADDR_I[7:0])
      pmca_pkg::CFG_OFS:    rd_mux = cfg_r;
      pmca_pkg::TXCTL_OFS:  rd_mux = {txctl_r[31:1], 1'b0};
      pmca_pkg::STATUS_OFS: rd_mux = {12'h000, be_r, rtry_r, nb_r,
                                      1'b0, sticky_r,
                                      state_r != pmca_pkg::ST_IDLE,
                                      state_r};
      pmca_pkg::TXFCS_OFS:  rd_mux = {16'h0000, txfcs_r};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data registered at address phase
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_r <= 32'h0000_0000;
    end else if (acc & ~HWRITE_I) begin
      rdata_r <= rd_mux;
    end
  end

  // Configuration and transmit registers
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      cfg_r   <= {pmca_pkg::HPW_RST, pmca_pkg::SPB_RST, pmca_pkg::RTY_RST,
                  pmca_pkg::NB_LIM_RST, pmca_pkg::MAX_BE_RST,
                  pmca_pkg::MIN_BE_RST};
      txctl_r <= '0;
      txfcs_r <= 16'h0000;
    end else if (wr_pend_r) begin
      if (wr_addr_r == pmca_pkg::CFG_OFS) begin
        cfg_r <= HWDATA_I;
      end
      // Request is frozen while an access runs
      if (start_wr) begin
        txctl_r <= HWDATA_I;
      end
      if ((wr_addr_r == pmca_pkg::TXFCS_OFS) &&
          (state_r == pmca_pkg::ST_IDLE)) begin
        txfcs_r <= HWDATA_I[15:0];
      end
    end
  end

  // Request and exponent as they stand once BACKOFF is entered, so the
  // delay loaded on entry never uses the previous request's values
  assign txctl_nxt = start_wr ? pmca_pkg::pmca_txctl_s'(HWDATA_I) : txctl_r;
  // Exponent value that the attempt counter block will store
  always_comb begin
    be_nxt = be_r;
    if (start_wr || ((state_r == pmca_pkg::ST_ACKWAIT) && collide
        && !ack_hit)) begin
      be_nxt = cfg_r.min_be;
    end else if ((state_r == pmca_pkg::ST_SENSE) && CS_VALID_I
                 && CS_BUSY_I) begin
      be_nxt = be_inc;
    end
  end
  assign rand_mask = 16'((17'h1 << be_nxt) - 17'h1);
  always_comb begin
    delay = 16'h0001 + (lfsr_r & rand_mask);
    if (!txctl_nxt.high_prio) begin
      delay = delay + {8'h00, cfg_r.hp_window_slots};
    end
    if (txctl_nxt.burst) begin
      delay = 16'h0000;
    end
  end

  // saturated exponent step, max may equal min
  assign be_inc = (be_r >= cfg_r.max_be) ? cfg_r.max_be : be_r + 4'h1;
  // limit compare on the counter after increment
  assign nb_over = (nb_r + 4'h1) > cfg_r.attempt_limit;
  assign rtry_over = (rtry_r + 4'h1) > cfg_r.frame_retry_limit;
  // group traffic never asks for ack
  assign want_ack = txctl_r.ack_req & ~txctl_r.group_addr;
  assign ack_hit = RESP_VALID_I & (RESP_KIND_I == pmca_pkg::RESP_ACK)
                   & (RESP_FCS_I == txfcs_r);
  assign collide = (resp_cnt_r == 16'h0000) |
                   (RESP_VALID_I & ~ack_hit);
  assign period_end = SYM_TICK_I &
                      (sym_r + 8'h01 >= cfg_r.sym_per_period);

  // Free running pseudo-random source
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      lfsr_r <= pmca_pkg::LFSR_SEED;
    end else begin
      lfsr_r <= {lfsr_r[14:0],
                 lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end

  // Access sequencer
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r <= pmca_pkg::ST_IDLE;
    end else begin
      case (state_r)
        pmca_pkg::ST_IDLE: begin
          if (start_wr) begin
            state_r <= pmca_pkg::ST_BACKOFF;
          end
        end
        pmca_pkg::ST_BACKOFF: begin
          if ((slots_r == 16'h0000) ||
              ((slots_r == 16'h0001) && period_end)) begin
            state_r <= pmca_pkg::ST_SENSE;
          end
        end
        pmca_pkg::ST_SENSE: begin
          if (CS_VALID_I && CS_BUSY_I) begin
            state_r <= nb_over ? pmca_pkg::ST_IDLE : pmca_pkg::ST_BACKOFF;
          end else if (CS_VALID_I) begin
            state_r <= pmca_pkg::ST_TX;
          end
        end
        pmca_pkg::ST_TX: begin
          if (TX_DONE_I) begin
            state_r <= want_ack ? pmca_pkg::ST_ACKWAIT : pmca_pkg::ST_IDLE;
          end
        end
        pmca_pkg::ST_ACKWAIT: begin
          if (ack_hit || (collide && rtry_over)) begin
            state_r <= pmca_pkg::ST_IDLE;
          end else if (collide) begin
            state_r <= pmca_pkg::ST_BACKOFF;
          end
        end
        default: state_r <= pmca_pkg::ST_IDLE;
      endcase
    end
  end

  // Attempt counter and exponent
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      nb_r <= 4'h0;
      be_r <= 4'h0;
    end else if (start_wr || ((state_r == pmca_pkg::ST_ACKWAIT)
                 && collide && !ack_hit)) begin
      nb_r <= 4'h0;
      be_r <= cfg_r.min_be;
    end else if ((state_r == pmca_pkg::ST_SENSE) && CS_VALID_I
                 && CS_BUSY_I) begin
      nb_r <= nb_r + 4'h1;
      be_r <= be_inc;
    end
  end

  // Retransmission counter
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      rtry_r <= 4'h0;
    end else if (start_wr) begin
      rtry_r <= 4'h0;
    end else if ((state_r == pmca_pkg::ST_ACKWAIT) && collide
                 && !ack_hit && !rtry_over) begin
      rtry_r <= rtry_r + 4'h1;
    end
  end

  // Backoff period and slot counters
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      slots_r <= 16'h0000;
      sym_r   <= 8'h00;
    end else if (state_r != pmca_pkg::ST_BACKOFF) begin
      // Delay drawn with the request and exponent of the entry edge
      slots_r <= delay;
      sym_r   <= 8'h00;
    end else if (period_end) begin
      slots_r <= slots_r - 16'h0001;
      sym_r   <= 8'h00;
    end else if (SYM_TICK_I) begin
      sym_r   <= sym_r + 8'h01;
    end
  end

  // Response wait timer
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      resp_cnt_r <= 16'h0000;
    end else if (state_r != pmca_pkg::ST_ACKWAIT) begin
      resp_cnt_r <= 16'(pmca_pkg::RESP_WAIT_CYC);
    end else if (resp_cnt_r != 16'h0000) begin
      resp_cnt_r <= resp_cnt_r - 16'h0001;
    end
  end

  // Sticky outcome flags, set wins over clear
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      sticky_r <= 3'b000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (st_clr && HWDATA_I[pmca_pkg::ST_DONE + i]) begin
          sticky_r[i] <= 1'b0;
        end
      end
      if (((state_r == pmca_pkg::ST_TX) && TX_DONE_I && !want_ack) ||
          ((state_r == pmca_pkg::ST_ACKWAIT) && ack_hit)) begin
        sticky_r[0] <= 1'b1;
      end
      if ((state_r == pmca_pkg::ST_SENSE) && CS_VALID_I && CS_BUSY_I
          && nb_over) begin
        sticky_r[pmca_pkg::ST_CAF - pmca_pkg::ST_DONE] <= 1'b1;
      end
      if ((state_r == pmca_pkg::ST_ACKWAIT) && collide && !ack_hit
          && rtry_over) begin
        sticky_r[pmca_pkg::ST_NACK - pmca_pkg::ST_DONE] <= 1'b1;
      end
    end
  end

  assign CS_REQ_O = (state_r == pmca_pkg::ST_BACKOFF) &&
                    ((slots_r == 16'h0000) ||
                     ((slots_r == 16'h0001) && period_end));
  assign TX_START_O = (state_r == pmca_pkg::ST_SENSE) && CS_VALID_I
                      && !CS_BUSY_I;
  assign TX_ACK_REQ_O = want_ack;

  always_comb begin
    pmca_pkg::pmca_seghdr_s h;
    h = '0;
    h.tone_map_request     = txctl_r.tone_map_req;
    h.contention_control   = txctl_r.burst;
    h.access_priority_flag = txctl_r.high_prio;
    h.last_segment_flag    = txctl_r.last_seg;
    h.segment_count        = txctl_r.seg_count;
    h.segment_length       = txctl_r.seg_length;
    SEG_HDR_O = h;
  end

  // Receive side acknowledgement and duplicate filter
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ACK_REQ_O  <= 1'b0;
      ACK_FCS_O  <= 16'h0000;
      RX_DUP_O   <= 1'b0;
      last_seq_r <= 8'h00;
      last_sc_r  <= 6'h00;
      last_ok_r  <= 1'b0;
    end else begin
      ACK_REQ_O <= RX_VALID_I & RX_FCS_OK_I & RX_FOR_ME_I
                   & RX_CAN_HANDLE_I;
      RX_DUP_O  <= 1'b0;
      if (RX_VALID_I && RX_FCS_OK_I && RX_FOR_ME_I && RX_CAN_HANDLE_I) begin
        ACK_FCS_O  <= RX_FCS_I;
        // same sequence and count is a copy
        RX_DUP_O   <= last_ok_r && (last_seq_r == RX_SEQ_I)
                      && (last_sc_r == RX_SEG_CNT_I);
        last_seq_r <= RX_SEQ_I;
        last_sc_r  <= RX_SEG_CNT_I;
        last_ok_r  <= 1'b1;
      end
    end
  end
endmodule

// ### tb/pmca_asserts.sv
// Purpose: Port checks of the channel access block
// Assumes: One clock, reset asynchronous and active high
// Notes:   Bound to every pmca_top instance
`timescale 1ns/10ps
module pmca_asserts (
  input wire logic        CLOCK_I,
  input wire logic        RST_I,
  input wire logic        HREADYOUT_O,
  input wire logic        HRESP_O,
  input wire logic        CS_REQ_O,
  input wire logic        CS_VALID_I,
  input wire logic        CS_BUSY_I,
  input wire logic        TX_START_O,
  input wire logic [23:0] SEG_HDR_O,
  input wire logic        RX_VALID_I,
  input wire logic        RX_FCS_OK_I,
  input wire logic        RX_FOR_ME_I,
  input wire logic        RX_CAN_HANDLE_I,
  input wire logic [15:0] RX_FCS_I,
  input wire logic        ACK_REQ_O,
  input wire logic [15:0] ACK_FCS_O,
  input wire logic        RX_DUP_O
);
  logic pend_r;  // Sense answer outstanding
  logic good;    // Frame qualifies for an ack
  assign good = RX_FCS_OK_I && RX_FOR_ME_I && RX_CAN_HANDLE_I;
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  // Remember a sense request until the PHY answers
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      pend_r <= 1'b0;
    end else if (CS_REQ_O) begin
      pend_r <= 1'b1;
    end else if (CS_VALID_I) begin
      pend_r <= 1'b0;
    end
  end
  idle_tx_a: assert property (pend_r && CS_VALID_I && !CS_BUSY_I
    |-> TX_START_O) else $error("idle answer gave no start");
  start_cause_a: assert property (TX_START_O
    |-> pend_r && CS_VALID_I && !CS_BUSY_I) else $error("start uncaused");
  busy_hold_a: assert property (pend_r && CS_VALID_I && CS_BUSY_I
    |-> !TX_START_O ##1 !TX_START_O) else $error("start on busy");
  sense_pulse_a: assert property (CS_REQ_O |=> !CS_REQ_O)
    else $error("sense request longer than one cycle");
  bus_okay_a: assert property (HREADYOUT_O && !HRESP_O)
    else $error("bus not ready or not okay");
  hdr_rsvd_a: assert property (SEG_HDR_O[23:20] == 4'h0)
    else $error("header upper bits set");
  ack_gen_a: assert property (RX_VALID_I && good
    |=> ACK_REQ_O && ACK_FCS_O == $past(RX_FCS_I))
    else $error("ack missing or wrong check value");
  ack_deny_a: assert property (RX_VALID_I && !good
    |=> !ACK_REQ_O) else $error("ack for refused frame");
  ack_cause_a: assert property (ACK_REQ_O |-> $past(RX_VALID_I))
    else $error("ack without frame");
  dup_ack_a: assert property (RX_DUP_O |-> ACK_REQ_O)
    else $error("duplicate flag without ack");
endmodule
bind pmca_top pmca_asserts u_chk (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .HREADYOUT_O(HREADYOUT_O),
  .HRESP_O(HRESP_O), .CS_REQ_O(CS_REQ_O), .CS_VALID_I(CS_VALID_I),
  .CS_BUSY_I(CS_BUSY_I), .TX_START_O(TX_START_O),
  .SEG_HDR_O(SEG_HDR_O), .RX_VALID_I(RX_VALID_I),
  .RX_FCS_OK_I(RX_FCS_OK_I), .RX_FOR_ME_I(RX_FOR_ME_I),
  .RX_CAN_HANDLE_I(RX_CAN_HANDLE_I), .RX_FCS_I(RX_FCS_I),
  .ACK_REQ_O(ACK_REQ_O), .ACK_FCS_O(ACK_FCS_O), .RX_DUP_O(RX_DUP_O)
);

// ### tb/pmca_phy_model.sv
// Purpose: Behavioural PHY beside the channel access block
// Assumes: Same clock as the block
// Notes:   Busy answer follows busy_i at answer time
`timescale 1ns/10ps
module pmca_phy_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic cs_req_i,
  input  wire logic tx_start_i,
  input  wire logic busy_i,
  output logic      sym_tick_o,
  output logic      cs_valid_o,
  output logic      cs_busy_o,
  output logic      tx_done_o
);
  logic [2:0] sd_r;  // Cycles left to the sense answer
  logic [2:0] td_r;  // Cycles left to end of frame
  // Symbol tick every second cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sym_tick_o <= 1'b0;
    end else begin
      sym_tick_o <= ~sym_tick_o;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sd_r       <= 3'h0;
      cs_valid_o <= 1'b0;
      cs_busy_o  <= 1'b0;
    end else begin
      if (cs_req_i) begin
        sd_r <= 3'h3;
      end else if (sd_r != 3'h0) begin
        sd_r <= sd_r - 3'h1;
      end
      cs_valid_o <= (sd_r == 3'h1);
      // Busy line toggles outside the answer
      cs_busy_o  <= (sd_r == 3'h1) ? busy_i : ~cs_busy_o;
    end
  end
  // End of frame some cycles after the start
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      td_r      <= 3'h0;
      tx_done_o <= 1'b0;
    end else begin
      if (tx_start_i) begin
        td_r <= 3'h5;
      end else if (td_r != 3'h0) begin
        td_r <= td_r - 3'h1;
      end
      tx_done_o <= (td_r == 3'h1);
    end
  end
endmodule

// ### tb/pmca_tb.sv
// Purpose: Self-checking bench of the channel access block
// Assumes: Zero-wait register bus, behavioural PHY
// Notes:   Response and receive inputs come from the bench
`timescale 1ns/10ps
module testbench;
  logic clk, rst, hsel, hwrite, hrdy, hrsp, busy;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans, rkind;
  logic [2:0]  hsize;
  logic tick, csreq, csv, csb, txs, txack, txd, rv;
  logic rxv, rxok, rxme, rxcan, ackreq, dup;
  logic [23:0] hdr;
  logic [15:0] rfcs, rxfcs, ackfcs;
  logic [7:0]  rxseq;
  logic [5:0]  rxsc;
  int miscompares, tests_run;
  pmca_top i_dut (.CLOCK_I(clk), .RST_I(rst), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hrdy),
    .HREADYOUT_O(hrdy), .HRESP_O(hrsp), .HRDATA_O(hrdata),
    .SYM_TICK_I(tick), .CS_REQ_O(csreq), .CS_VALID_I(csv),
    .CS_BUSY_I(csb), .TX_START_O(txs), .TX_ACK_REQ_O(txack),
    .SEG_HDR_O(hdr), .TX_DONE_I(txd), .RESP_VALID_I(rv),
    .RESP_KIND_I(rkind), .RESP_FCS_I(rfcs), .RX_VALID_I(rxv),
    .RX_FCS_OK_I(rxok), .RX_FOR_ME_I(rxme),
    .RX_CAN_HANDLE_I(rxcan), .RX_FCS_I(rxfcs), .RX_SEQ_I(rxseq),
    .RX_SEG_CNT_I(rxsc), .ACK_REQ_O(ackreq), .ACK_FCS_O(ackfcs),
    .RX_DUP_O(dup));
  pmca_phy_model u_phy (.clk_i(clk), .rst_i(rst), .cs_req_i(csreq),
    .tx_start_i(txs), .busy_i(busy), .sym_tick_o(tick),
    .cs_valid_o(csv), .cs_busy_o(csb), .tx_done_o(txd));
  // Clock of 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Verdict and end of run
  task automatic stop_test;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One comparison
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // Single word transfer, address then data phase
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    htrans <= pmca_pkg::HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  // Wait for frame start (0) or frame end (1)
  task automatic wait_ev(input int s);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!((s == 0) ? txs === 1'b1 : txd === 1'b1) && n < 3000);
    chk(n < 3000, "event never came");
  endtask
  // Read status until the sequencer is idle
  task automatic poll;
    int n;
    n = 0;
    do begin
      ahb(1'b0, pmca_pkg::STATUS_OFS, 32'h0);
      n++;
    end while (q[3] !== 1'b0 && n < 1000);
    chk(n < 1000, "sequencer stays busy");
  endtask
  // Answer the transmitter
  task automatic resp(input logic [1:0] k, input logic [15:0] f);
    @(posedge clk);
    rv    <= 1'b1;
    rkind <= k;
    rfcs  <= f;
    @(posedge clk);
    rv    <= 1'b0;
    rkind <= ~k;
    rfcs  <= ~f;
  endtask
  // Reset values, readback, unmapped place
  task automatic t_regs;
    ahb(1'b0, pmca_pkg::CFG_OFS, 32'h0);
    chk(q === 32'h04013453, "config reset value");
    ahb(1'b0, pmca_pkg::STATUS_OFS, 32'h0);
    chk(q === 32'h0, "status reset value");
    ahb(1'b1, pmca_pkg::CFG_OFS, 32'h02023210);
    ahb(1'b0, pmca_pkg::CFG_OFS, 32'h0);
    chk(q === 32'h02023210, "config readback");
    ahb(1'b0, 8'h10, 32'h0);
    chk(q === 32'h0, "unmapped read");
  endtask
  // Burst to a group: no backoff, no ack asked
  task automatic t_group;
    ahb(1'b1, pmca_pkg::CFG_OFS, 32'h04013453);
    ahb(1'b1, pmca_pkg::TXCTL_OFS, 32'h0000001d);
    #1;
    chk(csreq === 1'b1, "burst sense not at once");
    wait_ev(0);
    chk(txack === 1'b0, "ack asked for group");
    chk(hdr === 24'h040000, "burst header");
    wait_ev(1);
    poll;
    chk((q & 32'h7f) === 32'h10, "group done");
    ahb(1'b1, pmca_pkg::STATUS_OFS, 32'h70);
  endtask
  // Busy channel until access failure
  task automatic t_busy;
    busy <= 1'b1;
    ahb(1'b1, pmca_pkg::CFG_OFS, 32'h04013143);
    ahb(1'b1, pmca_pkg::TXCTL_OFS, 32'h00000001);
    poll;
    chk((q & 32'h000f0f3f) === 32'h00040220, "access fail");
    busy <= 1'b0;
    ahb(1'b1, pmca_pkg::STATUS_OFS, 32'h70);
  endtask
  // Refused replies then a matching ack
  task automatic t_arq;
    logic [1:0]  k[3];
    logic [15:0] f[3];
    k = '{pmca_pkg::RESP_NACK, pmca_pkg::RESP_ACK, pmca_pkg::RESP_ACK};
    f = '{16'h1234, 16'h4321, 16'h1234};
    ahb(1'b1, pmca_pkg::CFG_OFS, 32'h04013453);
    ahb(1'b1, pmca_pkg::TXFCS_OFS, 32'h00001234);
    ahb(1'b1, pmca_pkg::TXCTL_OFS, 32'h015502c5);
    for (int i = 0; i < 3; i++) begin
      wait_ev(0);
      chk(hdr === 24'h011555, "segment header");
      chk(txack === 1'b1, "ack not asked");
      wait_ev(1);
      resp(k[i], f[i]);
    end
    poll;
    chk((q & 32'hf07f) === 32'h2010, "retries then done");
    ahb(1'b1, pmca_pkg::STATUS_OFS, 32'h70);
  endtask
  // Silence after the frame with no retry left
  task automatic t_noack;
    ahb(1'b1, pmca_pkg::CFG_OFS, 32'h04010453);
    ahb(1'b1, pmca_pkg::TXCTL_OFS, 32'h00000027);
    wait_ev(0);
    chk(hdr === 24'h0a0000, "tone map and priority");
    wait_ev(1);
    poll;
    chk((q & 32'h7f) === 32'h40, "no-ack failure");
    ahb(1'b1, pmca_pkg::STATUS_OFS, 32'h70);
  endtask
  // Received frames: good, refused three ways, duplicate
  task automatic t_rx;
    logic [4:0] ok, me, cn, ea, ed;
    ok = 5'b11101;
    me = 5'b11011;
    cn = 5'b10111;
    ea = 5'b10001;
    ed = 5'b10000;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      rxv   <= 1'b1;
      rxok  <= ok[i];
      rxme  <= me[i];
      rxcan <= cn[i];
      rxfcs <= 16'haa00 + 16'(i);
      @(posedge clk);
      rxv <= 1'b0;
      #1;
      chk(ackreq === ea[i], "ack request");
      chk(dup === ed[i], "duplicate flag");
      if (ea[i]) begin
        chk(ackfcs === 16'haa00 + 16'(i), "echoed value");
      end
    end
  endtask
  // Main sequence
  initial begin
    miscompares = 0;
    tests_run = 0;
    rst = 1'b1;
    {hsel, hwrite, busy, rv, rxv, rxok, rxme, rxcan} = 8'h80;
    {haddr, hwdata, rfcs, rxfcs} = 96'h0;
    {htrans, rkind} = 4'h0;
    hsize = 3'h2;
    rxseq = 8'h07;
    rxsc = 6'h02;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_group;
    t_busy;
    t_arq;
    t_noack;
    t_rx;
    stop_test;
  end
  // Cut a hang short
  initial begin
    #(8 * 60000);
    miscompares++;
    stop_test;
  end
endmodule
